//--- common/tpim_pkg.sv
// Package: constants, register map and carrier types of the timer group
package tpim_pkg;
	localparam int W16 = 16;
	localparam int W8 = 8;
	localparam int NCH = 5;
	localparam int AW = 6;
	localparam int DW = 16;
	// Register offsets (word index on the plain port)
	localparam logic [AW-1:0] A_CTRL = 6'h00;
	localparam logic [AW-1:0] A_W_PRE = 6'h01;
	localparam logic [AW-1:0] A_W_PER = 6'h02;
	localparam logic [AW-1:0] A_W_CNT = 6'h03;
	localparam logic [AW-1:0] A_CHMODE = 6'h04;
	localparam logic [AW-1:0] A_N0_PRE = 6'h05;
	localparam logic [AW-1:0] A_N0_PER = 6'h06;
	localparam logic [AW-1:0] A_N0_CMP = 6'h07;
	localparam logic [AW-1:0] A_N1_PRE = 6'h08;
	localparam logic [AW-1:0] A_N1_PER = 6'h09;
	localparam logic [AW-1:0] A_N1_CMP = 6'h0A;
	localparam logic [AW-1:0] A_STAT = 6'h0B;
	localparam logic [AW-1:0] A_MASK = 6'h0C;
	localparam logic [AW-1:0] A_N_CNT = 6'h0D;
	localparam logic [AW-1:0] A_CH_BASE = 6'h10;
	// Control bits
	localparam int C_WEN = 0;
	localparam int C_N0EN = 1;
	localparam int C_N1EN = 2;
	localparam int C_IR = 3;
	// Status bits: 0 wide wrap, 1..5 channel, 6 narrow0 wrap, 7 narrow0 cmp, 8 n1 wrap, 9 n1 cmp
	localparam int NEV = 10;
	localparam int S_WWRAP = 0;
	localparam int S_CH0 = 1;
	localparam int S_N0WRAP = 6;
	localparam int S_N0CMP = 7;
	localparam int S_N1WRAP = 8;
	localparam int S_N1CMP = 9;
	localparam logic [DW-1:0] ZERO16 = 16'h0000;
	localparam logic [DW-1:0] PER_RST = 16'hFFFF;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} tpim_bus_req_t;
endpackage

//--- rtl/tpim_narrow.sv
// Narrow 8-bit timer with prescaler, period and one PWM compare channel
`timescale 1ns/1ps
`default_nettype none
module tpim_narrow (
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	input  wire logic       en_in,
	input  wire logic [7:0] pre_in,
	input  wire logic [7:0] per_in,
	input  wire logic [7:0] cmp_in,
	output logic      [7:0] cnt_out,
	output logic            pwm_out,
	output logic            wrap_out,
	output logic            match_out
);
	import tpim_pkg::*;
	logic [7:0] pre_q;
	logic       tick;
	assign tick = en_in && (pre_q >= pre_in);

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in || !en_in || tick) begin
			pre_q <= 8'h00;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cnt_out <= 8'h00;
		end else if (tick) begin
			cnt_out <= (cnt_out >= per_in) ? 8'h00 : cnt_out + 8'h01;
		end
	end

	// ----------------------------------------
	// Events and PWM (high while below compare)
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			wrap_out  <= 1'b0;
			match_out <= 1'b0;
			pwm_out   <= 1'b0;
		end else begin
			wrap_out  <= tick && (cnt_out >= per_in);
			match_out <= tick && (cnt_out == cmp_in);
			pwm_out   <= en_in && (cnt_out < cmp_in);
		end
	end
endmodule
`default_nettype wire

//--- rtl/tpim_top.sv
// Timer group: 16-bit timer with five channels, two 8-bit timers, IR AND output
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Wide 16-bit counter, programmable prescaler, wraps at programmable period.
// - Five wide channels, each with its own 16-bit compare value.
// - Each wide channel selects PWM output or input-edge capture of count.
// - IR mode: wide counter steps per narrow-0 period; output is AND of both.
// - Two narrow 8-bit timers, own prescaler, wrap at 8-bit period.
// - Each narrow timer has one 8-bit compare channel usable as PWM.
// - DMA requests let a DMA move data to single timer registers.
module tpim_top (
	input  wire logic                        clock_in,
	input  wire logic                        reset_n_in,
	input  wire logic [tpim_pkg::AW-1:0]     addr_in,
	input  wire logic [tpim_pkg::DW-1:0]     wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	input  wire logic [tpim_pkg::NCH-1:0]    cap_in,
	output logic      [tpim_pkg::DW-1:0]     rdata_out,
	output logic      [tpim_pkg::NCH-1:0]    ch_pwm_out,
	output logic      [1:0]                  n_pwm_out,
	output logic                             ir_out,
	output logic                             irq_out,
	output logic                             dma_wide_req_out,
	output logic      [1:0]                  dma_n_req_out
);
	import tpim_pkg::*;

	tpim_bus_req_t req;
	assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [3:0]      ctrl_q;
	logic [DW-1:0]   wpre_q;
	logic [DW-1:0]   wper_q;
	logic [NCH-1:0]  chcap_q;
	logic [NCH-1:0]  chrise_q;
	logic [7:0]      npre_q [2];
	logic [7:0]      nper_q [2];
	logic [7:0]      ncmp_q [2];
	logic [NEV-1:0]  mask_q;
	logic [NEV-1:0]  stat_q;
	logic [DW-1:0]   chval_q [NCH];
	logic [DW-1:0]   wcnt_q;
	logic [DW-1:0]   wpc_q;

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ctrl_q   <= 4'h0;
			wpre_q   <= ZERO16;
			wper_q   <= PER_RST;
			chcap_q  <= 5'h00;
			chrise_q <= 5'h1F;
			mask_q   <= 10'h000;
			for (int i = 0; i < 2; i++) begin
				npre_q[i] <= 8'h00;
				nper_q[i] <= 8'hFF;
				ncmp_q[i] <= 8'h00;
			end
		end else if (req.wr) begin
			case (req.addr)
				A_CTRL:   ctrl_q <= req.wdata[3:0];
				A_W_PRE:  wpre_q <= req.wdata;
				A_W_PER:  wper_q <= req.wdata;
				A_CHMODE: begin
					chcap_q  <= req.wdata[4:0];
					chrise_q <= req.wdata[12:8];
				end
				A_N0_PRE: npre_q[0] <= req.wdata[7:0];
				A_N0_PER: nper_q[0] <= req.wdata[7:0];
				A_N0_CMP: ncmp_q[0] <= req.wdata[7:0];
				A_N1_PRE: npre_q[1] <= req.wdata[7:0];
				A_N1_PER: nper_q[1] <= req.wdata[7:0];
				A_N1_CMP: ncmp_q[1] <= req.wdata[7:0];
				A_MASK:   mask_q <= req.wdata[NEV-1:0];
				default:  ;
			endcase
		end
	end

	// ----------------------------------------
	// Narrow timers
	// ----------------------------------------
	logic [7:0] ncnt [2];
	logic [1:0] npwm;
	logic [1:0] nwrap;
	logic [1:0] nmatch;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_n
			tpim_narrow u_n (
				.clock_in   (clock_in),
				.reset_n_in (reset_n_in),
				.en_in      (ctrl_q[C_N0EN + g]),
				.pre_in     (npre_q[g]),
				.per_in     (nper_q[g]),
				.cmp_in     (ncmp_q[g]),
				.cnt_out    (ncnt[g]),
				.pwm_out    (npwm[g]),
				.wrap_out   (nwrap[g]),
				.match_out  (nmatch[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Wide timer
	// ----------------------------------------
	logic wtick;
	logic wwrap;
	assign wtick = ctrl_q[C_WEN] &&
		(ctrl_q[C_IR] ? nwrap[0] : (wpc_q >= wpre_q));
	assign wwrap = wtick && (wcnt_q >= wper_q);

	always_ff @(posedge clock_in) begin
		if (!reset_n_in || !ctrl_q[C_WEN] || ctrl_q[C_IR] || wpc_q >= wpre_q) begin
			wpc_q <= ZERO16;
		end else begin
			wpc_q <= wpc_q + 16'h0001;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			wcnt_q <= ZERO16;
		end else if (req.wr && req.addr == A_W_CNT) begin
			wcnt_q <= ZERO16; // Any write restarts the count
		end else if (wtick) begin
			wcnt_q <= wwrap ? ZERO16 : wcnt_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Wide channels: compare or capture
	// ----------------------------------------
	// Inputs taken as synchronous; one flop gives a previous level for edges
	logic [NCH-1:0] cap_prev_q;
	logic [NCH-1:0] ch_ev;
	logic [NCH-1:0] ch_pwm_d;

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cap_prev_q <= 5'h00;
		end else begin
			cap_prev_q <= cap_in;
		end
	end

	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic edge_hit;
			assign edge_hit = chrise_q[g] ? (cap_in[g] && !cap_prev_q[g])
				: (!cap_in[g] && cap_prev_q[g]);
			assign ch_ev[g] = chcap_q[g] ? edge_hit
				: (wtick && wcnt_q == chval_q[g]);
			assign ch_pwm_d[g] = !chcap_q[g] && ctrl_q[C_WEN]
				&& (wcnt_q < chval_q[g]);

			always_ff @(posedge clock_in) begin
				if (!reset_n_in) begin
					chval_q[g] <= ZERO16;
				end else if (chcap_q[g] && edge_hit) begin
					chval_q[g] <= wcnt_q;
				end else if (req.wr && req.addr == A_CH_BASE + AW'(g)) begin
					chval_q[g] <= req.wdata;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	logic [NEV-1:0] ev;
	assign ev = {nmatch[1], nwrap[1], nmatch[0], nwrap[0], ch_ev, wwrap};

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			stat_q <= 10'h000;
		end else begin
			// Set wins over a write-one clear in the same cycle
			stat_q <= (stat_q & ~((req.wr && req.addr == A_STAT) ?
				req.wdata[NEV-1:0] : 10'h000)) | ev;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(stat_q & mask_q);
		end
	end

	// ----------------------------------------
	// Outputs and DMA triggers
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ch_pwm_out       <= 5'h00;
			n_pwm_out        <= 2'h0;
			ir_out           <= 1'b0;
			dma_wide_req_out <= 1'b0;
			dma_n_req_out    <= 2'h0;
		end else begin
			ch_pwm_out       <= ch_pwm_d;
			n_pwm_out        <= npwm;
			// Channel 0 carries the envelope, narrow 0 the carrier
			ir_out           <= ctrl_q[C_IR] && ch_pwm_d[0] && npwm[0];
			dma_wide_req_out <= wwrap || (|ch_ev);
			dma_n_req_out    <= nwrap;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			rdata_out <= ZERO16;
		end else if (req.rd) begin
			rdata_out <= ZERO16;
			case (req.addr)
				A_CTRL:   rdata_out <= {12'h000, ctrl_q};
				A_W_PRE:  rdata_out <= wpre_q;
				A_W_PER:  rdata_out <= wper_q;
				A_W_CNT:  rdata_out <= wcnt_q;
				A_CHMODE: rdata_out <= {3'h0, chrise_q, 3'h0, chcap_q};
				A_N0_PRE: rdata_out <= {8'h00, npre_q[0]};
				A_N0_PER: rdata_out <= {8'h00, nper_q[0]};
				A_N0_CMP: rdata_out <= {8'h00, ncmp_q[0]};
				A_N1_PRE: rdata_out <= {8'h00, npre_q[1]};
				A_N1_PER: rdata_out <= {8'h00, nper_q[1]};
				A_N1_CMP: rdata_out <= {8'h00, ncmp_q[1]};
				A_STAT:   rdata_out <= {6'h00, stat_q};
				A_MASK:   rdata_out <= {6'h00, mask_q};
				A_N_CNT:  rdata_out <= {ncnt[1], ncnt[0]};
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (req.addr == A_CH_BASE + AW'(i)) begin
							rdata_out <= chval_q[i];
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- tb/tpim_top_asserts.sv
// Checker: port assertions for the timer group
`timescale 1ns/1ps
`default_nettype none
module tpim_top_asserts import tpim_pkg::*; (
	input wire logic           clock_in,
	input wire logic           reset_n_in,
	input wire logic [AW-1:0]  addr_in,
	input wire logic [DW-1:0]  wdata_in,
	input wire logic           wr_in,
	input wire logic           rd_in,
	input wire logic [NCH-1:0] cap_in,
	input wire logic [DW-1:0]  rdata_out,
	input wire logic [NCH-1:0] ch_pwm_out,
	input wire logic [1:0]     n_pwm_out,
	input wire logic           ir_out,
	input wire logic           irq_out,
	input wire logic           dma_wide_req_out,
	input wire logic [1:0]     dma_n_req_out
);
	// --------
	// Register shadow
	// --------
	logic [DW-1:0] shd_q [0:15];
	logic [15:0]   wrt_q;
	logic [7:0]    exp_q;
	logic          chk_q;
	logic          rw;
	// Low byte only, so one check covers wide and narrow registers
	assign rw = addr_in inside {A_W_PRE, A_W_PER, A_N0_PRE, A_N0_PER, A_N0_CMP, A_N1_PRE,
		A_N1_PER, A_N1_CMP};
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			wrt_q     <= 16'h0000;
			shd_q[0]  <= 16'h0000;
			shd_q[4]  <= 16'h1F00;
			shd_q[12] <= 16'h0000;
		end else if (wr_in && addr_in < 6'h10) begin
			shd_q[addr_in[3:0]] <= wdata_in;
			wrt_q[addr_in[3:0]] <= 1'b1;
		end
	end
	always_ff @(posedge clock_in) begin
		chk_q <= reset_n_in && rd_in && rw && wrt_q[addr_in[3:0]];
		exp_q <= shd_q[addr_in[3:0]][7:0];
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	// --------
	// Assertions
	// --------
	AST_RDBACK: assert property (chk_q |-> rdata_out[7:0] == exp_q)
		else $error("readback differs from write");
	AST_UNMAPPED: assert property (rd_in && (addr_in inside {6'h0E, 6'h0F} || addr_in > 6'h14)
		|=> rdata_out == 16'h0000) else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!rd_in |=> $stable(rdata_out))
		else $error("read data moved without read");
	AST_IR_GATE: assert property (ir_out |-> $past(shd_q[0][C_IR]))
		else $error("ir output outside ir mode");
	AST_PWM_GATE: assert property (ch_pwm_out != 5'h00 |-> $past(shd_q[0][C_WEN])
		&& (ch_pwm_out & $past(shd_q[4][4:0])) == 5'h00) else $error("pwm on idle channel");
	AST_IRQ_MASK: assert property (irq_out |-> $past(shd_q[12][NEV-1:0]) != 10'h000)
		else $error("irq with all masked");
	AST_MASK_ZERO: assert property (wr_in && addr_in == A_MASK && wdata_in[NEV-1:0] == 10'h000
		|-> ##2 !irq_out) else $error("irq after mask cleared");
	AST_DMA_N_GATE: assert property ((dma_n_req_out & ~($past(shd_q[0][2:1]) |
		$past(shd_q[0][2:1], 2))) == 2'b00) else $error("narrow dma while stopped");
	COV_IR: cover property (ir_out);
	COV_IRQ: cover property ($rose(irq_out));
	COV_NDMA: cover property (dma_n_req_out != 2'b00);
endmodule
bind tpim_top tpim_top_asserts u_chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .cap_in(cap_in),
	.rdata_out(rdata_out), .ch_pwm_out(ch_pwm_out), .n_pwm_out(n_pwm_out), .ir_out(ir_out),
	.irq_out(irq_out), .dma_wide_req_out(dma_wide_req_out), .dma_n_req_out(dma_n_req_out));
`default_nettype wire

//--- tb/tb_top.sv
// Testbench: timer group against fixed expected values
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tpim_pkg::*;
	logic           clock_in, reset_n_in, wr_in, rd_in, ir_out, irq_out, dma_wide_req_out;
	logic [AW-1:0]  addr_in;
	logic [DW-1:0]  wdata_in, rdata_out, d;
	logic [NCH-1:0] cap_in, ch_pwm_out;
	logic [1:0]     n_pwm_out, dma_n_req_out;
	logic [DW-1:0]  q [$];
	int             error_cnt, samples_checked, cyc, n, seed, k;
	wire [6:0] mon = {n_pwm_out[1], dma_n_req_out[1], n_pwm_out[0], dma_n_req_out[0],
		ir_out, ch_pwm_out[0], dma_wide_req_out};
	localparam logic [AW-1:0] TA [8] = '{A_W_PRE, A_W_PER, A_N0_PRE, A_N0_PER, A_N0_CMP,
		A_N1_PRE, A_N1_PER, A_N1_CMP};
	tpim_top uut (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .cap_in(cap_in),
		.rdata_out(rdata_out), .ch_pwm_out(ch_pwm_out), .n_pwm_out(n_pwm_out),
		.ir_out(ir_out), .irq_out(irq_out), .dma_wide_req_out(dma_wide_req_out),
		.dma_n_req_out(dma_n_req_out));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	// --------
	// Bus and measurement tasks
	// --------
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR t=%0t seen %0h exp %0h", $time, s, e);
		end
	endtask
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(posedge clock_in);
		v = rdata_out;
	endtask
	// Cycles between two pulses; sampled mid-cycle, away from the edge
	task gap(input int s, output int g);
		g = 0;
		@(negedge clock_in);
		while (mon[s] !== 1'b1 && g < 3000) begin
			@(negedge clock_in);
			g++;
		end
		g = 0;
		do begin
			@(negedge clock_in);
			g++;
		end while (mon[s] !== 1'b1 && g < 3000);
		@(posedge clock_in);
	endtask
	task hi(input int s, input int w, output int h);
		h = 0;
		repeat (w) begin
			@(negedge clock_in);
			h += (mon[s] === 1'b1);
		end
		@(posedge clock_in);
	endtask
	task end_of_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// --------
	// Main sequence
	// --------
	initial begin
		seed = 32'h8AAD;
		{reset_n_in, wr_in, rd_in, addr_in, wdata_in, cap_in} = '0;
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		rd(A_W_PER, d);
		chk(d, 16'hFFFF);
		rd(A_N1_PER, d);
		chk(d, 16'h00FF);
		rd(A_CHMODE, d);
		chk(d, 16'h1F00);
		wr(6'h0F, 16'h1234);
		rd(6'h0F, d);
		chk(d, 16'h0000);
		for (k = 0; k < 8; k++) begin
			d = $random(seed);
			q.push_back(k < 2 ? d : d & 16'h00FF);
			wr(TA[k], d);
		end
		for (k = 0; k < 8; k++) begin
			rd(TA[k], d);
			chk(d, q.pop_front());
		end
		// Compare values above the period keep channel match events off; their PWM stays high
		for (k = 0; k < NCH; k++) wr(A_CH_BASE + AW'(k), 16'hFFFF);
		wr(A_W_PRE, 16'h0002);
		wr(A_W_PER, 16'h0009);
		wr(A_CTRL, 16'h0001);
		gap(0, n);
		chk(n, 3 * 10);
		wr(A_CH_BASE, 16'h0004);
		hi(1, 30, n);
		chk(n, 4 * 3);
		rd(A_STAT, d);
		chk(d[1:0], 2'b11);
		wr(A_MASK, 16'h0000);
		repeat (2) @(posedge clock_in);
		chk(irq_out, 1'b0);
		wr(A_MASK, 16'h0001);
		repeat (2) @(posedge clock_in);
		chk(irq_out, 1'b1);
		wr(A_CTRL, 16'h0000);
		wr(A_STAT, 16'h03FF);
		rd(A_STAT, d);
		chk(d, 16'h0000);
		chk(irq_out, 1'b0);
		wr(A_W_CNT, 16'h0007);
		rd(A_W_CNT, d);
		chk(d, 16'h0000);
		for (k = 0; k < 2; k++) begin
			wr(A_N0_PRE + AW'(3 * k), 16'h0001);
			wr(A_N0_PER + AW'(3 * k), 16'h0009);
			wr(A_N0_CMP + AW'(3 * k), 16'h0004);
			wr(A_CTRL, 16'h0002 << k);
			gap(3 + 2 * k, n);
			chk(n, 2 * 10);
			hi(4 + 2 * k, 20, n);
			chk(n, 4 * 2);
			rd(A_STAT, d);
			chk((d >> (6 + 2 * k)) & 16'h0003, 16'h0003);
		end
		// Wide steps once per narrow period; match at count 2, wrap at 3, one step apart
		wr(A_W_PER, 16'h0003);
		wr(A_W_PRE, 16'h0000);
		wr(A_CH_BASE, 16'h0002);
		wr(A_CTRL, 16'h000B);
		gap(0, n);
		chk(n, 20 * 1);
		hi(2, 80, n);
		chk(n, 2 * 8);
		wr(A_CTRL, 16'h0000);
		wr(A_W_CNT, 16'h0000);
		wr(A_CHMODE, 16'h1B06);
		wr(A_STAT, 16'h03FF);
		for (k = 0; k < 2; k++) begin
			cap_in <= k ? 5'h00 : 5'h06;
			repeat (3) @(posedge clock_in);
			rd(A_STAT, d);
			chk((d >> 2) & 16'h0003, k ? 16'h0003 : 16'h0001);
			rd(A_CH_BASE + AW'(1 + k), d);
			chk(d, 16'h0000);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
